// ### logic/lil_top.sv
// Latching indicator lamps with health lamp and life contact
`timescale 1ns/1ps
module lil_top (
  input  wire logic                                   clock,
  input  wire logic                                   nrst,
  input  wire logic [lil_pkg::ADDR_W-1:0]             reg_addr,
  input  wire logic [lil_pkg::CFG_W-1:0]              reg_wdata,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output logic      [lil_pkg::CFG_W-1:0]              reg_rdata,
  input  wire logic [lil_pkg::NUM_SIGS-1:0]           trig_sig,
  input  wire logic                                   clear_key,
  input  wire logic                                   group_lamp_ack_source,
  input  wire logic                                   prot_alarm,
  input  wire logic                                   prot_active,
  input  wire logic                                   int_fault,
  input  wire logic [lil_pkg::NUM_LAMPS-1:0]          retained_latch,
  input  wire logic                                   restore,
  output logic      [lil_pkg::NUM_LAMPS-1:0]          latch_store,
  output lil_pkg::lil_led_t [lil_pkg::NUM_LAMPS-1:0]  lamp,
  output lil_pkg::lil_led_t                           health_lamp,
  output logic                                        life_contact
);
  localparam int N = lil_pkg::NUM_LAMPS;

  lil_pkg::lil_cfg_t [N-1:0] cfg_reg;
  logic [31:0]               global_reg;
  logic                      remote_ack_reg;
  logic [N-1:0]              latch_reg;
  logic [N-1:0]              comb_act;
  logic [N-1:0]              idle;
  logic [N-1:0]              unassigned;
  logic [N-1:0]              shown;
  logic [N-1:0]              clr;
  logic [N-1:0]              latch_en;
  logic [31:0]               flash_cnt_reg;
  logic                      flash_reg;
  logic                      group_ok;

  // Config register writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_reg    <= '0;
      global_reg <= lil_pkg::GLOBAL_RST;
    end else if (reg_wr) begin
      for (int i = 0; i < N; i++) begin
        if (reg_addr == lil_pkg::LAMP_BASE + 8'(4 * i)) begin
          cfg_reg[i] <= reg_wdata;
        end
      end
      if (reg_addr == lil_pkg::GLOBAL_OFS) begin
        global_reg <= reg_wdata[31:0];
      end
    end
  end

  // Remote acknowledge command pulse
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      remote_ack_reg <= 1'b0;
    end else begin
      remote_ack_reg <= reg_wr && reg_addr == lil_pkg::CMD_OFS
                        && reg_wdata[lil_pkg::CMD_REMOTE_ACK];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      for (int i = 0; i < N; i++) begin
        if (reg_addr == lil_pkg::LAMP_BASE + 8'(4 * i)) begin
          reg_rdata <= cfg_reg[i];
        end
      end
      if (reg_addr == lil_pkg::GLOBAL_OFS) begin
        reg_rdata <= {17'h0, global_reg};
      end
      if (reg_addr == lil_pkg::STATUS_OFS) begin
        reg_rdata <= {33'h0, comb_act, latch_reg};
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  // Group acknowledge gated by remote permission
  assign group_ok = global_reg[lil_pkg::GLB_REMOTE_OK]
                    && (group_lamp_ack_source || remote_ack_reg);

  // Per-lamp trigger combination and clear conditions
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lamp
      logic [lil_pkg::NUM_SLOTS-1:0] eff;
      logic                          own_ack;
      logic                          latching;
      for (genvar s = 0; s < lil_pkg::NUM_SLOTS; s++) begin : g_slot
        logic [lil_pkg::SEL_W-1:0] sl;
        assign sl = cfg_reg[g].sel[s];
        assign eff[s] = (sl == lil_pkg::SEL_NONE || sl >= lil_pkg::SEL_W'(lil_pkg::NUM_SIGS))
                        ? 1'b0
                        : trig_sig[sl[4:0]] ^ cfg_reg[g].inv[s];
      end
      assign comb_act[g]   = |eff;
      assign idle[g]       = !comb_act[g];
      assign unassigned[g] = &{cfg_reg[g].sel[0] == lil_pkg::SEL_NONE,
                               cfg_reg[g].sel[1] == lil_pkg::SEL_NONE,
                               cfg_reg[g].sel[2] == lil_pkg::SEL_NONE,
                               cfg_reg[g].sel[3] == lil_pkg::SEL_NONE,
                               cfg_reg[g].sel[4] == lil_pkg::SEL_NONE};
      assign latching = cfg_reg[g].latch != lil_pkg::LIL_LATCH_OFF;
      assign latch_en[g] = latching;
      assign own_ack  = latching && cfg_reg[g].ack_sel != lil_pkg::SEL_NONE
                        && cfg_reg[g].ack_sel < lil_pkg::SEL_W'(lil_pkg::NUM_SIGS)
                        && trig_sig[cfg_reg[g].ack_sel[4:0]];
      // Acks only count in the cycle triggers are idle, never stored
      assign clr[g] = idle[g] && (clear_key || group_ok || own_ack
                      || !latching || unassigned[g]
                      || (cfg_reg[g].latch == lil_pkg::LIL_LATCH_ALARM && prot_alarm));
      assign shown[g] = latching ? latch_reg[g] : comb_act[g];
    end
  endgenerate

  // Latch storage; restored from retained copy after restart
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      latch_reg <= '0;
    end else if (restore) begin
      latch_reg <= retained_latch;
    end else begin
      latch_reg <= (latch_reg | (comb_act & latch_en)) & ~clr;
    end
  end

  // Copy of latch states for the retained store
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      latch_store <= '0;
    end else begin
      latch_store <= latch_reg;
    end
  end

  // Flash divider
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flash_cnt_reg <= '0;
      flash_reg     <= 1'b0;
    end else if (flash_cnt_reg == 32'(lil_pkg::FLASH_CYCLES - 1)) begin
      flash_cnt_reg <= '0;
      flash_reg     <= !flash_reg;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + 32'h1;
    end
  end

  function automatic lil_pkg::lil_led_t app_drive(lil_pkg::lil_app_t a, logic fl);
    lil_pkg::lil_led_t d;
    d = '0;
    case (a)
      lil_pkg::LIL_APP_GREEN: d.green = 1'b1;
      lil_pkg::LIL_APP_RED:   d.red   = 1'b1;
      lil_pkg::LIL_APP_RFL:   d.red   = fl;
      lil_pkg::LIL_APP_GFL:   d.green = fl;
      default:                d = '0;
    endcase
    return d;
  endfunction

  // Lamp appearance drive
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lamp <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        lamp[i] <= shown[i] ? app_drive(cfg_reg[i].on_appearance, flash_reg)
                            : app_drive(cfg_reg[i].off_appearance, flash_reg);
      end
    end
  end

  // Health lamp and life contact
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      health_lamp  <= '0;
      life_contact <= 1'b0;
    end else begin
      health_lamp.red <= 1'b0;
      if (global_reg[lil_pkg::GLB_BOOT_DONE] && prot_active) begin
        health_lamp.green <= 1'b1;
      end else begin
        health_lamp.green <= flash_reg;
      end
      life_contact <= global_reg[lil_pkg::GLB_BOOT_DONE] && prot_active
                      && !int_fault;
    end
  end

  a_clr_hold: assert property (@(posedge clock) disable iff (!nrst)
    (latch_reg[0] && comb_act[0] && !restore) |=> latch_reg[0])
    else $error("latched lamp cleared while trigger active");
  a_life_boot: assert property (@(posedge clock) disable iff (!nrst)
    !global_reg[lil_pkg::GLB_BOOT_DONE] |=> !life_contact)
    else $error("life contact energised during boot");
  a_group_gate: assert property (@(posedge clock) disable iff (!nrst)
    (!global_reg[lil_pkg::GLB_REMOTE_OK] |-> !group_ok))
    else $error("group ack without permission");
  a_follow_mode: assert property (@(posedge clock) disable iff (!nrst)
    (cfg_reg[0].latch == lil_pkg::LIL_LATCH_OFF && idle[0] && !restore) |=> !latch_reg[0])
    else $error("latch held while latching off");

  // Restore loads every latch from the retained copy
  a_restore_load: assert property (@(posedge clock) disable iff (!nrst)
    restore |=> latch_reg == $past(retained_latch))
    else $error("latch states not restored");

  // Retained copy trails the live latch states by one cycle
  a_store_copy: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> latch_store == $past(latch_reg))
    else $error("retained copy out of step");

  // Internal fault drops the life contact
  a_life_fault: assert property (@(posedge clock) disable iff (!nrst)
    int_fault |=> !life_contact)
    else $error("life contact energised with fault");

  // Health lamp follows the flash phase until boot completes with protection active
  a_health_boot: assert property (@(posedge clock) disable iff (!nrst)
    !global_reg[lil_pkg::GLB_BOOT_DONE] |=> health_lamp.green == $past(flash_reg))
    else $error("health lamp not flashing during boot");

  // Per-lamp checks, one set for every lamp
  for (genvar k = 0; k < N; k++) begin : g_chk
    // Front key pressed while the lamp latches and triggers are idle
    sequence s_key_ack;
      !restore && latch_en[k] && idle[k] && clear_key;
    endsequence
    // Latched lamp with a trigger still active
    sequence s_busy_hold;
      !restore && latch_reg[k] && !idle[k];
    endsequence
    // Own acknowledge source seen while triggers are idle
    sequence s_own_ack;
      !restore && idle[k] && g_lamp[k].own_ack;
    endsequence

    a_key_clear: assert property (@(posedge clock) disable iff (!nrst)
      s_key_ack |=> !latch_reg[k])
      else $error("clear key did not clear latch");

    a_busy_hold: assert property (@(posedge clock) disable iff (!nrst)
      s_busy_hold |=> latch_reg[k])
      else $error("latch cleared while trigger active");

    a_own_clear: assert property (@(posedge clock) disable iff (!nrst)
      s_own_ack |=> !latch_reg[k])
      else $error("own acknowledge did not clear latch");

    a_latch_set: assert property (@(posedge clock) disable iff (!nrst)
      (!restore && latch_en[k] && comb_act[k]) |=> latch_reg[k])
      else $error("active trigger not captured");

    a_group_clear: assert property (@(posedge clock) disable iff (!nrst)
      (!restore && latch_en[k] && idle[k] && group_ok) |=> !latch_reg[k])
      else $error("group acknowledge did not clear latch");

    a_alarm_clear: assert property (@(posedge clock) disable iff (!nrst)
      (!restore && idle[k] && prot_alarm
       && cfg_reg[k].latch == lil_pkg::LIL_LATCH_ALARM) |=> !latch_reg[k])
      else $error("alarm did not clear latch");

    a_unlatch_clear: assert property (@(posedge clock) disable iff (!nrst)
      (!restore && idle[k] && !latch_en[k]) |=> !latch_reg[k])
      else $error("latch kept after latching disabled");

    a_empty_clear: assert property (@(posedge clock) disable iff (!nrst)
      (!restore && unassigned[k]) |=> !latch_reg[k])
      else $error("latch kept with no trigger assigned");

    a_unassigned_off: assert property (@(posedge clock) disable iff (!nrst)
      unassigned[k] |-> !comb_act[k])
      else $error("unassigned lamp counted active");

    a_on_red: assert property (@(posedge clock) disable iff (!nrst)
      (shown[k] && cfg_reg[k].on_appearance == lil_pkg::LIL_APP_RED)
      |=> (lamp[k].red && !lamp[k].green))
      else $error("active red appearance wrong");

    a_on_none: assert property (@(posedge clock) disable iff (!nrst)
      (shown[k] && cfg_reg[k].on_appearance == lil_pkg::LIL_APP_NONE)
      |=> (!lamp[k].red && !lamp[k].green))
      else $error("active dark appearance wrong");

    a_off_green: assert property (@(posedge clock) disable iff (!nrst)
      (!shown[k] && cfg_reg[k].off_appearance == lil_pkg::LIL_APP_GREEN)
      |=> (lamp[k].green && !lamp[k].red))
      else $error("inactive green appearance wrong");
  end
endmodule // lil_top

// ### logic/lil_pkg.sv
// Package of constants and carrier types for the latching indicator logic
package lil_pkg;
  localparam int NUM_LAMPS     = 8;
  localparam int NUM_SLOTS     = 5;
  localparam int NUM_SIGS      = 32;
  localparam int SEL_W         = 6;
  localparam logic [5:0] SEL_NONE = 6'h3f;
  // Flash: 250 ms half period at 200 MHz
  localparam int CLK_MHZ       = 200;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_CYCLES  = FLASH_HALF_MS * 1000 * CLK_MHZ;
  localparam int ADDR_W        = 8;
  // Register offsets: per-lamp config at LAMP_BASE + 4*n, globals above the lamp block from 8'h40
  localparam logic [7:0] LAMP_BASE    = 8'h00;
  localparam logic [7:0] GLOBAL_OFS   = 8'h40;
  localparam logic [7:0] STATUS_OFS   = 8'h44;
  localparam logic [7:0] CMD_OFS      = 8'h48;
  // Global control fields
  localparam int GLB_REMOTE_OK  = 0;
  localparam int GLB_BOOT_DONE  = 1;
  localparam logic [31:0] GLOBAL_RST = 32'h0000_0000;
  // Command fields (write-one pulses)
  localparam int CMD_REMOTE_ACK = 0;

  typedef enum logic [2:0] {
    LIL_APP_NONE  = 3'h0,
    LIL_APP_GREEN = 3'h1,
    LIL_APP_RED   = 3'h2,
    LIL_APP_RFL   = 3'h3,
    LIL_APP_GFL   = 3'h4
  } lil_app_t;

  typedef enum logic [1:0] {
    LIL_LATCH_OFF   = 2'h0,
    LIL_LATCH_ON    = 2'h1,
    LIL_LATCH_ALARM = 2'h2
  } lil_latch_t;

  // Per-lamp configuration word layout (packed, 49 bits)
  typedef struct packed {
    logic [4:0]            inv;
    logic [NUM_SLOTS-1:0][SEL_W-1:0] sel;
    lil_latch_t            latch;
    logic [SEL_W-1:0]      ack_sel;
    lil_app_t              on_appearance;
    lil_app_t              off_appearance;
  } lil_cfg_t;

  localparam int CFG_W = $bits(lil_cfg_t);

  typedef struct packed {
    logic red;
    logic green;
  } lil_led_t;
endpackage

// ### tb/lil_far.sv
// Far-side model: signal pool, ack sources, protection status
`timescale 1ns/1ps
module lil_far (
  input  wire logic                        clock,
  output logic     [lil_pkg::NUM_SIGS-1:0] trig_sig,
  output logic                             clear_key,
  output logic                             group_lamp_ack_source,
  output logic                             prot_alarm,
  output logic                             prot_active,
  output logic                             int_fault
);
  // Everything idle at start
  initial begin
    trig_sig = '0;
    {clear_key, group_lamp_ack_source, prot_alarm, prot_active, int_fault} = '0;
  end
  // Level change of one pool signal after an edge
  task automatic set_sig(input int idx, input logic val);
    @(posedge clock);
    trig_sig[idx] <= val;
  endtask
  // One-cycle pulse: 0 clear key, 1 group ack, 2 alarm
  task automatic pulse(input int k);
    @(posedge clock);
    {prot_alarm, group_lamp_ack_source, clear_key} <= 3'(1 << k);
    @(posedge clock);
    {prot_alarm, group_lamp_ack_source, clear_key} <= 3'h0;
  endtask
  // Protection running and fault flag
  task automatic status(input logic act, input logic flt);
    @(posedge clock);
    prot_active <= act;
    int_fault <= flt;
  endtask
endmodule // lil_far

// ### tb/testbench.sv
// Self-checking bench for the latching indicator lamps
`timescale 1ns/1ps
module testbench;
  localparam logic [5:0] NO = lil_pkg::SEL_NONE;
  localparam logic [29:0] S1 = {NO, NO, NO, NO, 6'h01};
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic restore = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [lil_pkg::CFG_W-1:0] reg_wdata = '0, reg_rdata, rv;
  logic [lil_pkg::NUM_SIGS-1:0] trig_sig;
  logic clear_key, group_lamp_ack_source, prot_alarm, prot_active, int_fault, life_contact;
  logic [7:0] retained_latch = 8'h00, latch_store;
  lil_pkg::lil_led_t [7:0] lamp;
  lil_pkg::lil_led_t health_lamp;
  logic [29:0] sl;
  int num_errors = 0;
  int n_tests = 0;
  // Clock and devices
  always #2.5 clock = ~clock;
  lil_far i_far (.clock(clock), .trig_sig(trig_sig), .clear_key(clear_key),
    .group_lamp_ack_source(group_lamp_ack_source), .prot_alarm(prot_alarm),
    .prot_active(prot_active), .int_fault(int_fault));
  lil_top i_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_sig(trig_sig),
    .clear_key(clear_key), .group_lamp_ack_source(group_lamp_ack_source),
    .prot_alarm(prot_alarm), .prot_active(prot_active), .int_fault(int_fault),
    .retained_latch(retained_latch), .restore(restore), .latch_store(latch_store),
    .lamp(lamp), .health_lamp(health_lamp), .life_contact(life_contact));
  function automatic logic [48:0] cfg(input logic [4:0] iv, input logic [29:0] s,
      input int lt, input int on, input int off);
    cfg = {iv, s, 2'(lt), 6'h02, 3'(on), 3'(off)};
  endfunction
  task automatic chk(input string nm, input logic [48:0] e, input logic [48:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [48:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // Lamp 0 after settling; red when on, green when off
  task automatic lk(input logic on);
    repeat (4) @(posedge clock);
    #1 chk("lamp0", on ? 2'b10 : 2'b01, lamp[0]);
  endtask
  task automatic latch_up;
    i_far.set_sig(1, 1'b1);
    i_far.set_sig(1, 1'b0);
    lk(1'b1);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (8000) @(posedge clock);
    num_errors++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    rd(8'h80);
    chk("unmapped", 0, rv);
    rd(lil_pkg::GLOBAL_OFS);
    chk("global", 0, rv);
    chk("health_red", 0, health_lamp.red);
    chk("life_boot", 0, life_contact);
    i_far.status(1'b1, 1'b0);
    wr(lil_pkg::GLOBAL_OFS, 49'h2);
    repeat (4) @(posedge clock);
    #1 chk("health", 2'b01, health_lamp);
    chk("life_up", 1, life_contact);
    i_far.status(1'b1, 1'b1);
    repeat (4) @(posedge clock);
    #1 chk("life_fault", 0, life_contact);
    for (int s = 0; s < 5; s++) begin
      sl = {5{NO}};
      sl[s*6 +: 6] = 6'(s + 3);
      wr(8'h00, cfg(5'h00, sl, 0, 2, 1));
      i_far.set_sig(s + 3, 1'b1);
      lk(1'b1);
      i_far.set_sig(s + 3, 1'b0);
      lk(1'b0);
    end
    wr(8'h00, cfg(5'h01, S1, 0, 2, 1));
    lk(1'b1);
    wr(8'h00, cfg(5'h1f, {5{NO}}, 0, 2, 1));
    lk(1'b0);
    for (int c = 0; c < 3; c++) begin
      wr(8'h00, cfg(5'h00, S1, 0, c, 2 - c));
      repeat (4) @(posedge clock);
      #1 chk("off_app", {c == 0, c == 1}, lamp[0]);
      i_far.set_sig(1, 1'b1);
      repeat (4) @(posedge clock);
      #1 chk("on_app", {c == 2, c == 1}, lamp[0]);
      i_far.set_sig(1, 1'b0);
    end
    wr(8'h00, cfg(5'h00, S1, 0, 3, 4));
    repeat (4) @(posedge clock);
    #1 chk("off_flash", 0, lamp[0]);
    i_far.set_sig(1, 1'b1);
    repeat (4) @(posedge clock);
    #1 chk("on_flash", 0, lamp[0]);
    i_far.set_sig(1, 1'b0);
    wr(8'h00, cfg(5'h00, S1, 1, 2, 1));
    latch_up();
    chk("store", 1, latch_store[0]);
    rd(lil_pkg::STATUS_OFS);
    chk("status", 1, rv);
    i_far.set_sig(1, 1'b1);
    i_far.set_sig(2, 1'b1);
    i_far.set_sig(2, 1'b0);
    i_far.set_sig(1, 1'b0);
    lk(1'b1);
    i_far.set_sig(2, 1'b1);
    i_far.set_sig(2, 1'b0);
    lk(1'b0);
    latch_up();
    i_far.pulse(0);
    lk(1'b0);
    latch_up();
    i_far.pulse(1);
    lk(1'b1);
    wr(lil_pkg::GLOBAL_OFS, 49'h3);
    i_far.pulse(1);
    lk(1'b0);
    latch_up();
    i_far.pulse(2);
    lk(1'b1);
    wr(lil_pkg::CMD_OFS, 49'h1);
    lk(1'b0);
    latch_up();
    wr(8'h00, cfg(5'h00, S1, 0, 2, 1));
    wr(8'h00, cfg(5'h00, S1, 1, 2, 1));
    lk(1'b0);
    latch_up();
    wr(8'h00, cfg(5'h00, {5{NO}}, 1, 2, 1));
    wr(8'h00, cfg(5'h00, S1, 2, 2, 1));
    lk(1'b0);
    latch_up();
    i_far.pulse(2);
    lk(1'b0);
    @(posedge clock);
    retained_latch <= 8'h01;
    restore <= 1'b1;
    @(posedge clock);
    restore <= 1'b0;
    lk(1'b1);
    close_out();
  end
endmodule // testbench
